// ### common/cycle_if.sv
// machine cycle phase carried from the timer to the pin logic
interface cycle_if;
   logic [3:0] phase;
   logic       half_last;
   logic       second_half;

   modport timer (output phase, output half_last, output second_half);
   modport user  (input phase, input half_last, input second_half);
endinterface

// ### common/port_pins_params.svh
// constants for the port pins and external bus timing block
`ifndef PORT_PINS_PARAMS_SVH
`define PORT_PINS_PARAMS_SVH

// oscillator and machine cycle timing
`define OSC_PERIOD_NS          100
`define MACHINE_CYCLE_CLOCKS   12
`define HALF_CYCLE_CLOCKS      6
`define RESET_HOLD_CYCLES      2
`define RESET_HOLD_CLOCKS      (`RESET_HOLD_CYCLES * `MACHINE_CYCLE_CLOCKS)

// phase counter limits
`define LAST_PHASE             4'hb
`define HALF_LAST              4'h5
`define PHASE_WIDTH            4

// phases within a half cycle, as computed one clock before the pins
`define ALE_LAST               4'h1
`define ADDR_LAST              4'h2
`define STROBE_FIRST           4'h3
`define FETCH_CAPTURE          4'h1

// phases within a data machine cycle
`define DATA_STROBE_LAST       4'h9
`define DATA_DRIVE_LAST        4'ha
`define DATA_CAPTURE           4'ha

// top of internal program memory
`define INTERNAL_CODE_TOP      16'h3fff

// fourth port alternate bit positions
`define P3_SERIAL_RX           0
`define P3_SERIAL_TX           1
`define P3_INT_ZERO            2
`define P3_INT_ONE             3
`define P3_TIMER0              4
`define P3_TIMER1              5
`define P3_WRITE_STROBE        6
`define P3_READ_STROBE         7

// second port timer two bit positions
`define P1_TIMER2_COUNT        0
`define P1_TIMER2_TRIGGER      1

// synchroniser width: four ports plus the access select pin
`define SYNC_BITS              33
`define SYNC_RESET             33'h1_ffff_ffff
`endif

// ### common/port_pins_pkg.sv
// types for the port pins and external bus block
package port_pins_pkg;
   typedef enum logic [1:0] {
      SLOT_IDLE,
      SLOT_FETCH,
      SLOT_DATA
   } slot_t;
endpackage

// ### logic/machine_cycle_timer.sv
// twelve clock machine cycle phase counter
`include "port_pins_params.svh"

module machine_cycle_timer (
   input wire logic ref_clk,
   input wire logic rst_b,
   cycle_if.timer   cyc
);
   logic [3:0] phase_reg;

   // free running count 0..11, one machine cycle per wrap
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= 4'h0;
      end else if (phase_reg == `LAST_PHASE) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'h1;
      end
   end

   // half cycle markers
   assign cyc.phase       = phase_reg;
   assign cyc.second_half = (phase_reg > `HALF_LAST);
   assign cyc.half_last   = (phase_reg == `HALF_LAST) || (phase_reg == `LAST_PHASE);
endmodule

// ### logic/port_and_external_bus_pins.sv
// pin logic for four ports, address latch strobe and external bus cycles
`include "port_pins_params.svh"

module port_and_external_bus_pins (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  port0_in,
   output logic      [7:0]  port0_out,
   output logic      [7:0]  port0_oe,
   input  wire logic [7:0]  port1_in,
   output logic      [7:0]  port1_out,
   output logic      [7:0]  port1_oe,
   input  wire logic [7:0]  port2_in,
   output logic      [7:0]  port2_out,
   output logic      [7:0]  port2_oe,
   input  wire logic [7:0]  port3_in,
   output logic      [7:0]  port3_out,
   output logic      [7:0]  port3_oe,
   input  wire logic        external_access_select,
   output logic             ale,
   output logic             program_store_strobe_b,
   input  wire logic [7:0]  port0_latch,
   input  wire logic [7:0]  port1_latch,
   input  wire logic [7:0]  high_port_output_latch,
   input  wire logic [7:0]  port3_latch,
   input  wire logic        serial_tx_bit,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   output logic             fetch_accept,
   output logic             fetch_done,
   output logic      [7:0]  fetch_data,
   output logic             code_from_pins,
   input  wire logic        xdata_req,
   input  wire logic        xdata_write,
   input  wire logic        pointer_external_move,
   input  wire logic [15:0] xdata_addr,
   input  wire logic [7:0]  xdata_wdata,
   output logic             xdata_accept,
   output logic             xdata_done,
   output logic      [7:0]  xdata_rdata,
   input  wire logic        verify_mode,
   input  wire logic [7:0]  verify_code,
   output logic      [15:0] verify_addr,
   output logic      [7:0]  port1_pins,
   output logic      [7:0]  port2_pins,
   output logic      [7:0]  port3_pins,
   output logic             timer2_count_input,
   output logic             timer2_trigger_input,
   output logic             serial_rx_bit,
   output logic             external_interrupt_zero,
   output logic             external_interrupt_one,
   output logic             timer0_input,
   output logic             timer1_input
);
   cycle_if cyc ();

   machine_cycle_timer u_timer (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .cyc     (cyc)
   );

   logic [`SYNC_BITS-1:0] raw;
   logic [`SYNC_BITS-1:0] sync1_reg;
   logic [`SYNC_BITS-1:0] sync2_reg;
   logic [`SYNC_BITS-1:0] sync3_reg;
   logic [`SYNC_BITS-1:0] filt_reg;
   logic [`SYNC_BITS-1:0] settled;
   port_pins_pkg::slot_t  slot_reg;
   port_pins_pkg::slot_t  done_kind_reg;
   logic [15:0]           addr_reg;
   logic [7:0]            wdata_reg;
   logic                  write_reg;
   logic                  wide_reg;
   logic [3:0]            hp;
   logic                  fetch_ext;
   logic                  take_data;
   logic                  take_fetch;
   logic                  ale_next;
   logic                  code_b_next;
   logic                  wr_b_next;
   logic                  rd_b_next;
   logic [7:0]            p0_out_next;
   logic [7:0]            p0_oe_next;
   logic [7:0]            hi_drive;
   logic [23:0]           quasi_val;
   logic [23:0]           quasi_prev_reg;
   logic [23:0]           quasi_rise_reg;
   logic [23:0]           quasi_oe_next;
   // per bit reset level of the synchroniser, every pin idles high
   localparam logic [`SYNC_BITS-1:0] sync_init = `SYNC_RESET;

   // three stage synchroniser per pin; a change counts once stages two and three agree
   assign raw = {external_access_select, port3_in, port2_in, port1_in, port0_in};
   genvar i;
   generate
      for (i = 0; i < `SYNC_BITS; i = i + 1) begin : g_sync
         assign settled[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               sync1_reg[i] <= sync_init[i];
               sync2_reg[i] <= sync_init[i];
               sync3_reg[i] <= sync_init[i];
               filt_reg[i]  <= sync_init[i];
            end else begin
               sync1_reg[i] <= raw[i];
               sync2_reg[i] <= sync1_reg[i];
               sync3_reg[i] <= sync2_reg[i];
               filt_reg[i]  <= settled[i];
            end
         end
      end
   endgenerate

   // phase within the current half cycle
   assign hp = cyc.second_half ? (cyc.phase - 4'(`HALF_CYCLE_CLOCKS)) : cyc.phase;

   // external fetch when select pin low or address beyond internal store
   assign fetch_ext  = !filt_reg[32] || (fetch_addr > `INTERNAL_CODE_TOP);
   assign take_data  = (cyc.phase == `LAST_PHASE) && xdata_req && !verify_mode;
   assign take_fetch = fetch_req && fetch_ext && !verify_mode;

   // bus slot chosen at the end of each half; a data access owns a whole cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_reg  <= port_pins_pkg::SLOT_IDLE;
         addr_reg  <= 16'h0000;
         wdata_reg <= 8'h00;
         write_reg <= 1'b0;
         wide_reg  <= 1'b0;
      end else if (cyc.half_last) begin
         if (take_data) begin
            slot_reg  <= port_pins_pkg::SLOT_DATA;
            addr_reg  <= xdata_addr;
            wdata_reg <= xdata_wdata;
            write_reg <= xdata_write;
            wide_reg  <= pointer_external_move;
         end else if (slot_reg == port_pins_pkg::SLOT_DATA && !cyc.second_half) begin
            slot_reg <= port_pins_pkg::SLOT_DATA;
         end else if (take_fetch) begin
            slot_reg <= port_pins_pkg::SLOT_FETCH;
            addr_reg <= fetch_addr;
         end else begin
            slot_reg <= port_pins_pkg::SLOT_IDLE;
         end
      end
   end

   // acceptance pulses and capture of returned bytes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_accept  <= 1'b0;
         xdata_accept  <= 1'b0;
         done_kind_reg <= port_pins_pkg::SLOT_IDLE;
      end else begin
         fetch_accept <= cyc.half_last && !take_data && take_fetch
                         && !(slot_reg == port_pins_pkg::SLOT_DATA && !cyc.second_half);
         xdata_accept <= cyc.half_last && take_data;
         if (cyc.half_last) begin
            done_kind_reg <= slot_reg;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_done  <= 1'b0;
         fetch_data  <= 8'h00;
         xdata_done  <= 1'b0;
         xdata_rdata <= 8'h00;
      end else begin
         fetch_done <= (done_kind_reg == port_pins_pkg::SLOT_FETCH) && (hp == `FETCH_CAPTURE);
         if ((done_kind_reg == port_pins_pkg::SLOT_FETCH) && (hp == `FETCH_CAPTURE)) begin
            fetch_data <= settled[7:0];
         end
         xdata_done <= (slot_reg == port_pins_pkg::SLOT_DATA) && (cyc.phase == `DATA_CAPTURE);
         if ((slot_reg == port_pins_pkg::SLOT_DATA) && (cyc.phase == `DATA_CAPTURE)
             && !write_reg) begin
            xdata_rdata <= settled[7:0];
         end
      end
   end

   // strobes: address latch every half except the second half of a data access
   always_comb begin
      ale_next    = (hp <= `ALE_LAST)
                    && !(slot_reg == port_pins_pkg::SLOT_DATA && cyc.second_half);
      code_b_next = !(slot_reg == port_pins_pkg::SLOT_FETCH && hp >= `STROBE_FIRST);
      wr_b_next   = !(slot_reg == port_pins_pkg::SLOT_DATA && write_reg
                      && cyc.phase >= `STROBE_FIRST && cyc.phase <= `DATA_STROBE_LAST);
      rd_b_next   = !(slot_reg == port_pins_pkg::SLOT_DATA && !write_reg
                      && cyc.phase >= `STROBE_FIRST && cyc.phase <= `DATA_STROBE_LAST);
   end

   // first port: verify code, bus address and data, or open drain latch
   always_comb begin
      if (verify_mode) begin
         p0_out_next = verify_code;
         p0_oe_next  = ~verify_code;
      end else if (slot_reg != port_pins_pkg::SLOT_IDLE && hp <= `ADDR_LAST
                   && !(slot_reg == port_pins_pkg::SLOT_DATA && cyc.second_half)) begin
         p0_out_next = addr_reg[7:0];
         p0_oe_next  = 8'hff;
      end else if (slot_reg == port_pins_pkg::SLOT_DATA && write_reg
                   && cyc.phase >= `STROBE_FIRST && cyc.phase <= `DATA_DRIVE_LAST) begin
         p0_out_next = wdata_reg;
         p0_oe_next  = 8'hff;
      end else if (slot_reg != port_pins_pkg::SLOT_IDLE) begin
         p0_out_next = 8'hff; // float to read the bus
         p0_oe_next  = 8'h00;
      end else begin
         p0_out_next = port0_latch;
         p0_oe_next  = ~port0_latch;
      end
   end

   // third port drives high address when the slot calls for it
   assign hi_drive = (slot_reg == port_pins_pkg::SLOT_FETCH
                      || (slot_reg == port_pins_pkg::SLOT_DATA && wide_reg))
                     ? 8'hff : 8'h00;

   // quasi bidirectional values; fourth port alternate outputs gate the latch
   assign quasi_val = {port3_latch & {rd_b_next, wr_b_next, 4'hf, serial_tx_bit, 1'b1},
                       high_port_output_latch, port1_latch};

   // drive low, or drive high hard for two clocks after a rise, else pullup only
   assign quasi_oe_next = ~quasi_val | (quasi_val & ~quasi_prev_reg) | quasi_rise_reg;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         quasi_prev_reg <= 24'hff_ffff;
         quasi_rise_reg <= 24'h00_0000;
      end else begin
         quasi_prev_reg <= quasi_val;
         quasi_rise_reg <= quasi_val & ~quasi_prev_reg;
      end
   end

   // registered pin drive; reset releases every port high at once
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         port0_out              <= 8'hff;
         port0_oe               <= 8'h00;
         port1_out              <= 8'hff;
         port1_oe               <= 8'h00;
         port2_out              <= 8'hff;
         port2_oe               <= 8'h00;
         port3_out              <= 8'hff;
         port3_oe               <= 8'h00;
         ale                    <= 1'b0;
         program_store_strobe_b <= 1'b1;
      end else begin
         port0_out              <= p0_out_next;
         port0_oe               <= p0_oe_next;
         port1_out              <= quasi_val[7:0];
         port1_oe               <= verify_mode ? 8'h00 : quasi_oe_next[7:0];
         port2_out              <= (hi_drive & addr_reg[15:8])
                                   | (~hi_drive & quasi_val[15:8]);
         port2_oe               <= verify_mode ? 8'h00
                                   : (hi_drive | quasi_oe_next[15:8]);
         port3_out              <= quasi_val[23:16];
         port3_oe               <= quasi_oe_next[23:16];
         ale                    <= ale_next;
         program_store_strobe_b <= code_b_next;
      end
   end

   // settled pin values for the core and the alternate functions
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_from_pins <= 1'b1;
         verify_addr    <= 16'hffff;
      end else begin
         code_from_pins <= fetch_ext;
         verify_addr    <= {filt_reg[23:16], filt_reg[15:8]};
      end
   end

   assign port1_pins              = filt_reg[15:8];
   assign port2_pins              = filt_reg[23:16];
   assign port3_pins              = filt_reg[31:24];
   assign timer2_count_input      = filt_reg[8 + `P1_TIMER2_COUNT];
   assign timer2_trigger_input    = filt_reg[8 + `P1_TIMER2_TRIGGER];
   assign serial_rx_bit           = filt_reg[24 + `P3_SERIAL_RX];
   assign external_interrupt_zero = filt_reg[24 + `P3_INT_ZERO];
   assign external_interrupt_one  = filt_reg[24 + `P3_INT_ONE];
   assign timer0_input            = filt_reg[24 + `P3_TIMER0];
   assign timer1_input            = filt_reg[24 + `P3_TIMER1];
endmodule

// ### testbench/ext_memory_model.sv
// external address latch with code and data memory on the multiplexed bus
module ext_memory_model (
   input wire logic       ale,
   input wire logic       program_store_strobe_b,
   input wire logic       read_b,
   input wire logic       write_b,
   input wire logic [7:0] bus_level,
   output logic           mem_drive,
   output logic [7:0]     mem_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] low_addr_reg;
   logic [7:0] data_mem [0:255];
   // latch closes on the falling strobe, so the bus must still hold the address
   always_ff @(negedge ale) low_addr_reg <= bus_level;
   // a write lands when the write strobe rises
   always @(posedge write_b) data_mem[low_addr_reg] = bus_level;
   // answer only while a read strobe is low; otherwise the bus floats
   assign mem_drive = !program_store_strobe_b || !read_b;
   assign mem_data  = !program_store_strobe_b ? (low_addr_reg ^ 8'h5a) : data_mem[low_addr_reg];
endmodule

// ### testbench/port_pins_assertions.sv
// timing checks on the port pins and external bus block outputs
module port_pins_assertions (
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       ale,
   input wire logic       program_store_strobe_b,
   input wire logic [7:0] port0_oe,
   input wire logic [7:0] port1_out,
   input wire logic [7:0] port1_oe,
   input wire logic [7:0] port2_out,
   input wire logic [7:0] port2_oe,
   input wire logic [7:0] port3_out,
   input wire logic [7:0] port3_oe,
   input wire logic [7:0] high_port_output_latch,
   input wire logic       pointer_external_move,
   input wire logic       fetch_accept,
   input wire logic       fetch_done,
   input wire logic       xdata_accept,
   input wire logic       xdata_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // low byte driven for two strobe clocks, then held one clock past the fall
   sequence addr_phase;
      (ale && port0_oe == 8'hff)[*2] ##1 (!ale && port0_oe == 8'hff);
   endsequence
   sequence ale_pulse;
      ale[*2] ##1 !ale;
   endsequence
   ale_width_a: assert property ($rose(ale) |-> ale_pulse)
      else $error("ale pulse width wrong");
   ale_rate_a: assert property ($rose(ale) |-> (##6 $rose(ale)) or (##12 $rose(ale)))
      else $error("ale rate wrong");
   fetch_address_a: assert property (
      fetch_accept |-> ##1 port2_oe == 8'hff ##0 addr_phase ##1 port0_oe == 8'h00)
      else $error("fetch address phase wrong");
   fetch_strobe_a: assert property (fetch_accept |->
      ##4 (!program_store_strobe_b)[*3] ##1 program_store_strobe_b)
      else $error("program strobe wrong on fetch");
   fetch_done_a: assert property (fetch_accept |-> ##8 fetch_done)
      else $error("fetch done late");
   data_ale_a: assert property (xdata_accept |-> ##1 addr_phase ##4 (!ale)[*2])
      else $error("data cycle ale wrong");
   data_strobe_a: assert property (xdata_accept |->
      ##4 (!(port3_out[6] && port3_out[7]))[*7] ##1 (port3_out[6] && port3_out[7]))
      else $error("data strobe wrong");
   data_quiet_a: assert property (xdata_accept |-> ##1 program_store_strobe_b[*8])
      else $error("program strobe active in data cycle");
   data_high_a: assert property (xdata_accept |-> ##1 (pointer_external_move ?
      port2_oe == 8'hff : port2_out == high_port_output_latch))
      else $error("high port wrong in data cycle");
   data_done_a: assert property (xdata_accept |-> ##11 xdata_done)
      else $error("data done late");
   reset_high_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rst_b |-> port1_out == 8'hff && (port1_oe | port2_oe | port3_oe) == 8'h00)
      else $error("ports not high in reset");
endmodule

bind port_and_external_bus_pins port_pins_assertions port_pins_assertions_inst (.*);

// ### testbench/test_port_and_external_bus_pins.sv
// self-checking bench for the port pins and external bus block
module test_port_and_external_bus_pins;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk, rst_b, external_access_select, serial_tx_bit, verify_mode;
   logic        fetch_req, xdata_req, xdata_write, pointer_external_move;
   logic [7:0]  port0_latch, port1_latch, high_port_output_latch, port3_latch;
   logic [7:0]  xdata_wdata, verify_code, ext1_low, ext2_low, ext3_low;
   logic [15:0] fetch_addr, xdata_addr, verify_addr;
   logic [7:0]  port0_in, port1_in, port2_in, port3_in, port0_out, port1_out;
   logic [7:0]  port2_out, port3_out, port0_oe, port1_oe, port2_oe, port3_oe;
   logic [7:0]  port1_pins, port2_pins, port3_pins, fetch_data, xdata_rdata, mem_data;
   logic        ale, program_store_strobe_b, fetch_accept, fetch_done, code_from_pins;
   logic        xdata_accept, xdata_done, timer2_count_input, timer2_trigger_input;
   logic        serial_rx_bit, external_interrupt_zero, external_interrupt_one;
   logic        timer0_input, timer1_input, mem_drive;
   int          n_mismatch = 0, comparisons = 0, cycles = 0;

   // released lines rise through pull-ups; the verify station pulls the first port up
   assign port0_in = (port0_oe & port0_out) | (~port0_oe & (mem_drive ? mem_data : 8'hff));
   assign port1_in = (port1_oe & port1_out) | (~port1_oe & ~ext1_low);
   assign port2_in = (port2_oe & port2_out) | (~port2_oe & ~ext2_low);
   assign port3_in = (port3_oe & port3_out) | (~port3_oe & ~ext3_low);

   port_and_external_bus_pins port_and_external_bus_pins_inst (.*);
   ext_memory_model ext_memory_model_inst (.ale(ale), .program_store_strobe_b(program_store_strobe_b),
      .read_b(port3_in[7]), .write_b(port3_in[6]), .bus_level(port0_in),
      .mem_drive(mem_drive), .mem_data(mem_data));

   // clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         give_verdict;
      end
   end

   task give_verdict;
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // wait, bounded, for accept or done of either group
   task wait_sig(input int sel);
      logic [3:0] flags;
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         flags = {xdata_done, fetch_done, xdata_accept, fetch_accept};
         if (flags[sel] === 1'b1) break;
      end
      chk({7'h00, flags[sel]}, 8'h01);
   endtask

   task count_ale(input int n, output int rises);
      logic prev;
      rises = 0;
      for (int k = 0; k < n; k++) begin
         prev = ale;
         @(negedge ref_clk);
         if (ale && !prev) rises++;
      end
   endtask

   task do_fetch(input logic [15:0] a);
      fetch_addr = a;
      fetch_req = 1'b1;
      wait_sig(0);
      fetch_req = 1'b0;
      @(negedge ref_clk);
      chk(port0_out, a[7:0]);
      chk(port2_out, a[15:8]);
      wait_sig(2);
      chk(fetch_data, a[7:0] ^ 8'h5a);
   endtask

   task do_xdata(input logic wr, input logic ptr, input logic [15:0] a, input logic [7:0] d);
      int r1, r2;
      xdata_write = wr;
      pointer_external_move = ptr;
      xdata_addr = a;
      xdata_wdata = d;
      xdata_req = 1'b1;
      wait_sig(1);
      xdata_req = 1'b0;
      count_ale(5, r1);
      chk(port0_oe, wr ? 8'hff : 8'h00);
      if (wr) chk(port0_out, d);
      chk(port2_out, ptr ? a[15:8] : high_port_output_latch);
      count_ale(6, r2);
      chk(8'(r1 + r2), 8'h01);
      chk({7'h00, xdata_done}, 8'h01);
      if (!wr) chk(xdata_rdata, d);
   endtask

   task reset_check;
      rst_b = 1'b0;
      #1;
      chk(port1_out, 8'hff);
      chk(port1_oe | port2_oe | port3_oe, 8'h00);
      chk({timer0_input, timer1_input, serial_rx_bit, 5'h1f}, 8'hff);
      port1_latch = 8'hff;
      repeat (24) @(negedge ref_clk);
      rst_b = 1'b1;
   endtask

   task t_internal;
      int acc;
      acc = 0;
      external_access_select = 1'b1;
      fetch_addr = 16'h3fff;
      repeat (6) @(negedge ref_clk);
      fetch_req = 1'b1;
      repeat (24) begin
         @(negedge ref_clk);
         if (fetch_accept === 1'b1) acc++;
      end
      fetch_req = 1'b0;
      chk(8'(acc), 8'h00);
      chk({7'h00, code_from_pins}, 8'h00);
      do_fetch(16'h4000);
      external_access_select = 1'b0;
   endtask

   task t_ports;
      port0_latch = 8'h0f;
      serial_tx_bit = 1'b0;
      ext1_low = 8'h01;
      ext2_low = 8'h80;
      ext3_low = 8'h25;
      repeat (8) @(negedge ref_clk);
      chk(port0_oe, 8'hf0);
      chk(port1_pins, 8'hfe);
      chk(port2_pins, 8'h1c);
      chk(port3_pins, 8'hd8);
      chk({timer2_trigger_input, timer2_count_input, 6'h00}, 8'h80);
      chk({serial_rx_bit, external_interrupt_zero, external_interrupt_one, timer0_input,
           timer1_input, 3'h0}, 8'h30);
      chk(port3_oe, 8'h02);
      chk(port3_out, 8'hfd);
      port0_latch = 8'hff;
      serial_tx_bit = 1'b1;
   endtask

   task t_verify;
      int acc;
      acc = 0;
      verify_mode = 1'b1;
      verify_code = 8'h3c;
      ext1_low = 8'hde;
      ext2_low = 8'hbc;
      ext3_low = 8'h00;
      fetch_req = 1'b1;
      xdata_req = 1'b1;
      repeat (14) begin
         @(negedge ref_clk);
         if (fetch_accept === 1'b1 || xdata_accept === 1'b1) acc++;
      end
      fetch_req = 1'b0;
      xdata_req = 1'b0;
      chk(8'(acc), 8'h00);
      chk(verify_addr[15:8], 8'h43);
      chk(verify_addr[7:0], 8'h21);
      chk(port0_oe, 8'hc3);
      chk(port1_oe | port2_oe, 8'h00);
      verify_mode = 1'b0;
      ext1_low = 8'h00;
      ext2_low = 8'h00;
   endtask

   // main sequence
   initial begin
      int r;
      rst_b = 1'b1;
      {external_access_select, verify_mode, fetch_req, xdata_req} = 4'h0;
      {xdata_write, pointer_external_move, serial_tx_bit} = 3'h1;
      {port0_latch, port1_latch, port3_latch} = 24'hff00ff;
      high_port_output_latch = 8'h9c;
      {xdata_wdata, verify_code, ext1_low, ext2_low, ext3_low} = 40'h0;
      {fetch_addr, xdata_addr} = 32'h0;
      #10;
      reset_check;
      repeat (6) @(negedge ref_clk);
      count_ale(12, r);
      chk(8'(r), 8'h02);
      do_fetch(16'h12ab);
      do_fetch(16'hfe01);
      t_internal;
      do_xdata(1'b1, 1'b1, 16'h3456, 8'hc3);
      do_xdata(1'b0, 1'b0, 16'h0056, 8'hc3);
      do_xdata(1'b1, 1'b0, 16'h0077, 8'h1e);
      do_xdata(1'b0, 1'b1, 16'hab77, 8'h1e);
      t_ports;
      t_verify;
      port1_latch = 8'h00;
      repeat (4) @(negedge ref_clk);
      #20;
      reset_check;
      do_fetch(16'h0042);
      give_verdict;
   end
endmodule
